// [verilog/fsq_pkg.sv]
// package: flash sector geometry, row line sizes and program limits
package fsq_pkg;
	// banks
	localparam logic       BANK_PROG      = 1'b0;
	localparam logic       BANK_DATA      = 1'b1;
	// sector counts and select width
	localparam int         PROG_SECTORS   = 3;
	localparam int         DATA_SECTORS   = 10;
	localparam int         SEC_W          = 10;
	// byte address widths
	localparam int         PROG_AW        = 12;
	localparam int         DATA_AW        = 12;
	localparam int         ADDR_W         = 12;
	// row line of 64 bytes: index width
	localparam int         ROW_BYTES_LOG2 = 6;
	localparam int         ROW_W          = ADDR_W - ROW_BYTES_LOG2;
	localparam int         ROWS           = 64;
	// program bank sector bases (bytes): 3.75 Kbyte, 128 byte, 128 byte
	localparam logic [11:0] PROG_S1_BASE  = 12'hF00;
	localparam logic [11:0] PROG_S2_BASE  = 12'hF80;
	// data bank sector bases: 1K,1K,512,512,256,256,128 x4
	localparam logic [11:0] DATA_S1_BASE  = 12'h400;
	localparam logic [11:0] DATA_S2_BASE  = 12'h800;
	localparam logic [11:0] DATA_S3_BASE  = 12'hA00;
	localparam logic [11:0] DATA_S4_BASE  = 12'hC00;
	localparam logic [11:0] DATA_S5_BASE  = 12'hD00;
	localparam logic [11:0] DATA_S6_BASE  = 12'hE00;
	localparam logic [11:0] DATA_S7_BASE  = 12'hE80;
	localparam logic [11:0] DATA_S8_BASE  = 12'hF00;
	localparam logic [11:0] DATA_S9_BASE  = 12'hF80;
	// program limits per row line between erases
	localparam logic [1:0] PROG_LIMIT     = 2'h1;
	localparam logic [1:0] DATA_LIMIT     = 2'h2;
	// erased cell value
	localparam logic [7:0] ERASED_BYTE    = 8'h00;
	localparam logic [1:0] CNT_RESET      = 2'h0;

	typedef enum logic [1:0] {
		FSQ_IDLE  = 2'b00,
		FSQ_ERASE = 2'b01,
		FSQ_DONE  = 2'b10
	} fsq_state_t;
endpackage

// [verilog/fsq_cnt_mem.sv]
// memory: per row line program counts, registered read data
`timescale 1ns/1ns
module fsq_cnt_mem
	import fsq_pkg::*;
(
	// clock
	input  wire logic             clk_sys,
	// access port
	input  wire logic [ROW_W:0]   addr,
	input  wire logic             we,
	input  wire logic [1:0]       wdata,
	output logic      [1:0]       rdata
);
	logic [1:0] mem [0:2*ROWS-1];

	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule // fsq_cnt_mem

// [verilog/fsq_seq.sv]
// flash sector erase and program bookkeeping sequencer
`timescale 1ns/1ns
module fsq_seq
	import fsq_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	// erase request
	input  wire logic              erase_req,
	input  wire logic              erase_bank,
	input  wire logic [SEC_W-1:0]  erase_sel,
	// program request
	input  wire logic              prog_req,
	input  wire logic              prog_bank,
	input  wire logic [ADDR_W-1:0] prog_addr,
	// status
	output logic                   busy,
	output logic                   erase_done,
	output logic                   prog_ok,
	output logic                   prog_err,
	output logic [1:0]             prog_count,
	output logic                   erased_zero
);
	typedef struct packed {
		fsq_state_t       st;
		logic             bank;
		logic [SEC_W-1:0] sel;
		logic [ROW_W-1:0] row;
		logic             pend;
		logic             pbank;
		logic             busy;
		logic             done;
		logic             ok;
		logic             err;
		logic [1:0]       cnt;
		logic             zero;
	} fsq_regs_t;

	fsq_regs_t  s_q;
	fsq_regs_t  s_d;
	logic [ROW_W:0] m_addr;
	logic           m_we;
	logic [1:0]     m_wdata;
	logic [1:0]     m_rdata;

	// sector index of a byte address in a bank
	function automatic logic [3:0] sector_of(input logic bank, input logic [ADDR_W-1:0] a);
		if (bank == BANK_PROG) begin
			if (a >= PROG_S2_BASE) return 4'h2;
			else if (a >= PROG_S1_BASE) return 4'h1;
			else return 4'h0;
		end
		if (a >= DATA_S9_BASE) return 4'h9;
		else if (a >= DATA_S8_BASE) return 4'h8;
		else if (a >= DATA_S7_BASE) return 4'h7;
		else if (a >= DATA_S6_BASE) return 4'h6;
		else if (a >= DATA_S5_BASE) return 4'h5;
		else if (a >= DATA_S4_BASE) return 4'h4;
		else if (a >= DATA_S3_BASE) return 4'h3;
		else if (a >= DATA_S2_BASE) return 4'h2;
		else if (a >= DATA_S1_BASE) return 4'h1;
		else return 4'h0;
	endfunction

	function automatic logic [1:0] limit_of(input logic bank);
		return (bank == BANK_PROG) ? PROG_LIMIT : DATA_LIMIT;
	endfunction

	fsq_cnt_mem u_mem (
		.clk_sys (clk_sys),
		.addr    (m_addr),
		.we      (m_we),
		.wdata   (m_wdata),
		.rdata   (m_rdata)
	);

	always_comb begin
		logic [3:0] sec;
		sec     = 4'h0;
		s_d     = s_q;
		s_d.done = 1'b0;
		s_d.ok   = 1'b0;
		s_d.err  = 1'b0;
		s_d.pend = 1'b0;
		m_addr  = {s_q.bank, s_q.row};
		m_we    = 1'b0;
		m_wdata = CNT_RESET;
		unique case (s_q.st)
			FSQ_IDLE: begin
				if (s_q.pend) begin
					// count read back one cycle after request
					if (m_rdata >= limit_of(s_q.pbank)) begin
						s_d.err = 1'b1;
						s_d.cnt = m_rdata;
					end else begin
						m_we    = 1'b1;
						m_wdata = m_rdata + 2'h1;
						s_d.ok  = 1'b1;
						s_d.cnt = m_rdata + 2'h1;
					end
					s_d.busy = 1'b0;
				end else if (erase_req && erase_sel != '0) begin
					s_d.st   = FSQ_ERASE;
					s_d.bank = erase_bank;
					s_d.sel  = (erase_bank == BANK_PROG) ? {7'h00, erase_sel[2:0]} : erase_sel;
					s_d.row  = '0;
					s_d.busy = 1'b1;
					s_d.zero = 1'b0;
				end else if (prog_req) begin
					m_addr   = {prog_bank, prog_addr[ADDR_W-1:ROW_BYTES_LOG2]};
					s_d.row  = prog_addr[ADDR_W-1:ROW_BYTES_LOG2];
					s_d.bank = prog_bank;
					s_d.pbank = prog_bank;
					s_d.pend = 1'b1;
					s_d.busy = 1'b1;
				end
			end
			FSQ_ERASE: begin
				// walk every row; rows in a selected sector are cleared whole
				sec = sector_of(s_q.bank, {s_q.row, 6'h00});
				if (s_q.sel[sec]) begin
					m_we    = 1'b1;
					m_wdata = CNT_RESET;
				end
				s_d.row = s_q.row + 1'b1;
				if (s_q.row == ROW_W'(ROWS - 1)) begin
					s_d.st = FSQ_DONE;
				end
			end
			FSQ_DONE: begin
				s_d.st   = FSQ_IDLE;
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.zero = 1'b1;
				s_d.cnt  = CNT_RESET;
			end
			default: begin
				s_d.st = FSQ_IDLE;
			end
		endcase
	end

	// counts memory is cleared by erase; after reset a full erase is expected
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s_q <= '{st: FSQ_IDLE, cnt: CNT_RESET, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign busy        = s_q.busy;
	assign erase_done  = s_q.done;
	assign prog_ok     = s_q.ok;
	assign prog_err    = s_q.err;
	assign prog_count  = s_q.cnt;
	assign erased_zero = s_q.zero;

	property p_err_limit;
		@(posedge clk_sys) disable iff (!rstn)
		prog_err |-> prog_count == limit_of(s_q.pbank);
	endproperty
	a_err_limit: assert property (p_err_limit) else $error("error without reached limit");

	property p_prog_answer;
		@(posedge clk_sys) disable iff (!rstn)
		(prog_req && !busy && !erase_req) |=> ##1 (prog_ok ^ prog_err);
	endproperty
	a_prog_answer: assert property (p_prog_answer) else $error("program request not answered");

	property p_prog_once;
		@(posedge clk_sys) disable iff (!rstn)
		(prog_ok && s_q.pbank == BANK_PROG) |-> prog_count == 2'h1;
	endproperty
	a_prog_once: assert property (p_prog_once) else $error("program bank row written twice");

	property p_data_twice;
		@(posedge clk_sys) disable iff (!rstn)
		(prog_ok && s_q.pbank == BANK_DATA) |-> prog_count <= DATA_LIMIT;
	endproperty
	a_data_twice: assert property (p_data_twice) else $error("data bank row over limit");

	property p_erase_len;
		@(posedge clk_sys) disable iff (!rstn)
		(s_q.st == FSQ_IDLE && s_d.st == FSQ_ERASE) |=> busy [*8] ##58 erase_done;
	endproperty
	a_erase_len: assert property (p_erase_len) else $error("erase length wrong");

	property p_zero_after;
		@(posedge clk_sys) disable iff (!rstn)
		erase_done |-> erased_zero && prog_count == CNT_RESET;
	endproperty
	a_zero_after: assert property (p_zero_after) else $error("erase not reading zero");

	property p_sector_map;
		@(posedge clk_sys) disable iff (!rstn)
		s_q.st == FSQ_ERASE && s_q.bank == BANK_PROG |-> s_q.sel[SEC_W-1:PROG_SECTORS] == '0;
	endproperty
	a_sector_map: assert property (p_sector_map) else $error("bad program bank sector");

	property p_data_map;
		@(posedge clk_sys) disable iff (!rstn)
		// the row at the last data sector base is cleared exactly when that sector is selected
		s_q.st == FSQ_ERASE && s_q.bank == BANK_DATA && s_q.row == DATA_S9_BASE[ADDR_W-1:ROW_BYTES_LOG2]
			|-> m_we == s_q.sel[DATA_SECTORS-1];
	endproperty
	a_data_map: assert property (p_data_map) else $error("data bank map wrong");

	c_erase: cover property (@(posedge clk_sys) disable iff (!rstn) erase_done);
	c_ok:    cover property (@(posedge clk_sys) disable iff (!rstn) prog_ok && prog_count == 2'h2);
	c_err:   cover property (@(posedge clk_sys) disable iff (!rstn) prog_err);
endmodule // fsq_seq

// [tb/fsq_seq_bench.sv]
// testbench: erase and program bookkeeping sequencer
`timescale 1ns/1ns
module fsq_seq_bench
	import fsq_pkg::*;
;
	// clock, reset and requests
	logic              clk_sys, rstn, erase_req, erase_bank, prog_req, prog_bank;
	logic [SEC_W-1:0]  erase_sel;
	logic [ADDR_W-1:0] prog_addr;
	// status
	logic              busy, erase_done, prog_ok, prog_err, erased_zero;
	logic [1:0]        prog_count;
	int                fails, comparisons;

	fsq_seq DUT (.clk_sys(clk_sys), .rstn(rstn), .erase_req(erase_req), .erase_bank(erase_bank),
		.erase_sel(erase_sel), .prog_req(prog_req), .prog_bank(prog_bank), .prog_addr(prog_addr),
		.busy(busy), .erase_done(erase_done), .prog_ok(prog_ok), .prog_err(prog_err),
		.prog_count(prog_count), .erased_zero(erased_zero));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask

	// erase request, then bounded wait for the done pulse
	task automatic erase(input logic bank, input logic [9:0] sel);
		int n;
		n = 0;
		erase_req = 1'b1;
		erase_bank = bank;
		erase_sel = sel;
		tick();
		erase_req = 1'b0;
		while (erase_done !== 1'b1 && n < 100) begin
			tick();
			n++;
			if (n == 1)
				chk({busy, erased_zero}, 12'h002, "erase start");
		end
		if (n >= 100) begin
			fails++;
			complete_run();
		end
		chk(12'(n), 12'(ROWS + 1), "erase latency");
		chk({busy, erased_zero, prog_count}, 12'h004, "erase end");
		tick();
		chk(erase_done, 12'h000, "done pulse length");
	endtask

	// program request and its answer one edge after the taking edge
	task automatic prog(input logic bank, input logic [11:0] addr, input logic ok, input logic [1:0] cnt);
		prog_req = 1'b1;
		prog_bank = bank;
		prog_addr = addr;
		tick();
		prog_req = 1'b0;
		chk(busy, 12'h001, "busy during check");
		tick();
		chk({busy, prog_ok, prog_err, prog_count}, {1'b0, ok, ~ok, cnt}, "program answer");
	endtask

	// empty selection is ignored and leaves the block idle
	task automatic empty_erase;
		erase_req = 1'b1;
		erase_sel = '0;
		tick();
		erase_req = 1'b0;
		chk(busy, 12'h000, "empty erase taken");
		tick();
		chk(busy, 12'h000, "empty erase late");
	endtask

	// count memory holds no reset value: clear every sector of both banks
	task automatic full_erase;
		erase(BANK_PROG, 10'h007);
		erase(BANK_DATA, 10'h3FF);
	endtask

	// program bank rows accept one program between erases
	task automatic prog_bank_once;
		prog(BANK_PROG, 12'hEC0, 1'b1, 2'h1);
		prog(BANK_PROG, 12'hF40, 1'b1, 2'h1);
		prog(BANK_PROG, 12'hF7F, 1'b0, 2'h1);
		prog(BANK_PROG, 12'hF80, 1'b1, 2'h1);
	endtask

	// data bank rows accept two programs between erases
	task automatic data_bank_twice;
		prog(BANK_DATA, 12'hE40, 1'b1, 2'h1);
		prog(BANK_DATA, 12'hE40, 1'b1, 2'h2);
		prog(BANK_DATA, 12'hE7F, 1'b0, 2'h2);
		prog(BANK_DATA, 12'hE80, 1'b1, 2'h1);
		prog(BANK_DATA, 12'hE80, 1'b1, 2'h2);
	endtask

	// single data sector erase clears that sector only
	task automatic data_sector_erase;
		erase(BANK_DATA, 10'h040);
		prog(BANK_DATA, 12'hE40, 1'b1, 2'h1);
		prog(BANK_DATA, 12'hE80, 1'b0, 2'h2);
	endtask

	// two program bank sectors erased together, sector 0 untouched
	task automatic prog_pair_erase;
		erase(BANK_PROG, 10'h006);
		prog(BANK_PROG, 12'hF40, 1'b1, 2'h1);
		prog(BANK_PROG, 12'hF80, 1'b1, 2'h1);
		prog(BANK_PROG, 12'hEC0, 1'b0, 2'h1);
	endtask

	initial begin
		{rstn, erase_req, erase_bank, prog_req, prog_bank, erase_sel, prog_addr} = '0;
		fails = 0;
		comparisons = 0;
		repeat (8) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
		chk({busy, erase_done, prog_ok, prog_err, prog_count, erased_zero}, 12'h000, "reset");
		empty_erase();
		full_erase();
		prog_bank_once();
		data_bank_twice();
		data_sector_erase();
		prog_pair_erase();
		complete_run();
	end
endmodule // fsq_seq_bench
